// *** ccs_params.svh ***
// Constants of the configuration start-up sequencer: register map, fields, defaults, counts.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef CCS_PARAMS_SVH
`define CCS_PARAMS_SVH

`define CCS_ADDR_W 12
`define CCS_ADDR_CTRL 12'h000
`define CCS_ADDR_LEN 12'h004
`define CCS_ADDR_OPT 12'h008
`define CCS_ADDR_STAT 12'h00c
`define CCS_ADDR_COUNT 12'h010

`define CCS_CTRL_START 0
`define CCS_CTRL_ABORT 1

`define CCS_OPT_DONE_LSB 0
`define CCS_OPT_IO_LSB 2
`define CCS_OPT_GSR_LSB 4
`define CCS_OPT_VALID 8

`define CCS_STEP_DONE_DEF 3'h1
`define CCS_STEP_IO_DEF 3'h2
`define CCS_STEP_GSR_DEF 3'h3
`define CCS_STEP_FINISH 3'h4

`define CCS_LEN_RESET 24'hffffff
`define CCS_OPT_RESET 32'h00000000
`define CCS_CONFIG_CLOCK_DIV 8

`endif

// *** ccs_pkg.sv ***
// Types shared by the configuration start-up sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package ccs_pkg;

   typedef enum logic [2:0]
   {
      CCS_MODE_SLAVE_SERIAL,
      CCS_MODE_MASTER_SERIAL,
      CCS_MODE_SYNC_PERIPH,
      CCS_MODE_ASYNC_PERIPH,
      CCS_MODE_MASTER_PAR_DOWN,
      CCS_MODE_MASTER_PAR_UP,
      CCS_MODE_RESERVED
   } ccs_mode_t;

   typedef enum logic [1:0]
   {
      CCS_ST_IDLE,
      CCS_ST_LOAD,
      CCS_ST_START,
      CCS_ST_FINISHED
   } ccs_state_t;

   // Start-up control handed to user logic
   typedef struct packed
   {
      logic done;
      logic gsr;
      logic io_en;
      logic finished;
   } ccs_wakeup_t;

endpackage

// *** ccs_sync.sv ***
// Two-flop synchroniser for pins from outside the system clock domain.
// Assumes the bits are independent levels.
`timescale 1ns/1ps
module ccs_sync
#(
   parameter int W = 1
)
(
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);
   logic [W-1:0] meta;

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
      begin
         meta <= '0;
         o_sync <= '0;
      end
      else
      begin
         meta <= i_async;
         o_sync <= meta;
      end
   end
endmodule

// *** ccs_event.sv ***
// One start-up event: fires once the step count reaches its programmed step, then holds.
// Assumes step count and tick come from the same clock domain.
`timescale 1ns/1ps
module ccs_event
(
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_clear,
   input wire logic i_active,
   input wire logic [2:0] i_step_cnt,
   input wire logic [2:0] i_step,
   output logic o_fired
);
   wire reach = i_active && (i_step_cnt >= i_step);

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n || i_clear)
         o_fired <= 1'b0;
      else if (reach)
         o_fired <= 1'b1;
   end
endmodule

// *** ccs_top.sv ***
// Configuration start-up sequencer: counts configuration clocks to the length count, then
// brings up completion flag, user I/O and set/reset release in a programmable order.
// Assumes an APB master on the system clock; config clock and mode pins are asynchronous.
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "ccs_params.svh"
module ccs_top
#(
   parameter int CONFIG_CLOCK_DIV = `CCS_CONFIG_CLOCK_DIV
)
(
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [`CCS_ADDR_W-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_config_clock,
   output logic o_config_clock,
   output logic o_config_clock_oe_n,
   input wire logic i_mode_select_bit2,
   input wire logic i_mode_select_bit1,
   input wire logic i_mode_select_bit0,
   output logic o_high_during_load_pin,
   output logic o_high_during_load_pin_oe_n,
   output logic o_low_during_load_pin_n,
   output logic o_low_during_load_pin_oe_n,
   output logic o_done,
   output logic o_gsr,
   output logic o_user_io_en,
   output logic o_clk_sel_user,
   output ccs_pkg::ccs_wakeup_t o_wakeup_primitive,
   input wire logic i_wakeup_gsr,
   input wire logic i_wakeup_gts
);
   if (CONFIG_CLOCK_DIV < 2 || CONFIG_CLOCK_DIV > 65535 || (CONFIG_CLOCK_DIV % 2) != 0)
   begin : g_bad_div
      $error("CONFIG_CLOCK_DIV must be even and in 2..65535");
   end

   ccs_pkg::ccs_state_t state;
   ccs_pkg::ccs_state_t next_state;
   ccs_pkg::ccs_mode_t mode;
   ccs_pkg::ccs_mode_t next_mode;
   logic [23:0] len_count;
   logic [31:0] opt;
   logic [23:0] clk_count;
   logic [2:0] step_cnt;
   logic [15:0] div_cnt;
   logic config_clock_out;
   logic config_clock_prev;
   logic done_fired;
   logic io_fired;
   logic gsr_fired;
   logic cfg_drive;
   logic [2:0] mode_pins;
   logic config_clock_in;

   // Pins from outside pass two flops before use
   ccs_sync #(.W(3)) u_sync_mode
   (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n),
      .i_async({i_mode_select_bit2, i_mode_select_bit1, i_mode_select_bit0}),
      .o_sync(mode_pins)
   );

   ccs_sync #(.W(1)) u_sync_config_clock
   (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n),
      .i_async(i_config_clock),
      .o_sync(config_clock_in)
   );

   // APB decode
   wire apb_setup = i_psel && !i_penable;
   wire apb_wr = i_psel && i_penable && i_pwrite;
   wire hit_ctrl = (i_paddr == `CCS_ADDR_CTRL);
   wire hit_len = (i_paddr == `CCS_ADDR_LEN);
   wire hit_opt = (i_paddr == `CCS_ADDR_OPT);
   wire hit_stat = (i_paddr == `CCS_ADDR_STAT);
   wire hit_count = (i_paddr == `CCS_ADDR_COUNT);
   wire hit_any = hit_ctrl || hit_len || hit_opt || hit_stat || hit_count;
   wire wr_start = apb_wr && hit_ctrl && i_pwdata[`CCS_CTRL_START];
   wire wr_abort = apb_wr && hit_ctrl && i_pwdata[`CCS_CTRL_ABORT];
   wire idle = (state == ccs_pkg::CCS_ST_IDLE);

   assign o_pready = 1'b1;
   assign o_pslverr = i_psel && i_penable && !hit_any;

   // Mode pin decode, sampled when loading starts
   always_comb
   begin
      unique case (mode_pins)
         3'h7: next_mode = ccs_pkg::CCS_MODE_SLAVE_SERIAL;
         3'h0: next_mode = ccs_pkg::CCS_MODE_MASTER_SERIAL;
         3'h3: next_mode = ccs_pkg::CCS_MODE_SYNC_PERIPH;
         3'h5: next_mode = ccs_pkg::CCS_MODE_ASYNC_PERIPH;
         3'h6: next_mode = ccs_pkg::CCS_MODE_MASTER_PAR_DOWN;
         3'h4: next_mode = ccs_pkg::CCS_MODE_MASTER_PAR_UP;
         default: next_mode = ccs_pkg::CCS_MODE_RESERVED;
      endcase
   end

   wire is_master = (mode == ccs_pkg::CCS_MODE_MASTER_SERIAL) ||
                    (mode == ccs_pkg::CCS_MODE_MASTER_PAR_DOWN) ||
                    (mode == ccs_pkg::CCS_MODE_MASTER_PAR_UP);
   wire clk_run = (state == ccs_pkg::CCS_ST_LOAD) || (state == ccs_pkg::CCS_ST_START);

   // Master modes make the config clock; slaves take it from the pin
   wire div_wrap = (div_cnt == 16'(CONFIG_CLOCK_DIV / 2 - 1));
   wire master_tick = is_master && clk_run && div_wrap && !config_clock_out;
   wire slave_tick = !is_master && config_clock_in && !config_clock_prev;
   wire tick = master_tick || slave_tick;

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
      begin
         div_cnt <= 16'h0000;
         config_clock_out <= 1'b0;
      end
      else if (!(is_master && clk_run))
      begin
         div_cnt <= 16'h0000;
         config_clock_out <= 1'b0;
      end
      else
      begin
         div_cnt <= div_wrap ? 16'h0000 : div_cnt + 16'h0001;
         config_clock_out <= div_wrap ? !config_clock_out : config_clock_out;
      end
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
         config_clock_prev <= 1'b0;
      else
         config_clock_prev <= config_clock_in;
   end

   assign o_config_clock = config_clock_out;
   assign o_config_clock_oe_n = !(is_master && clk_run);

   // Option fields from the OPT register written over APB; fall back to fixed order when absent
   wire opt_valid = opt[`CCS_OPT_VALID];
   wire [2:0] opt_done = {1'b0, opt[`CCS_OPT_DONE_LSB +: 2]};
   wire [2:0] opt_io = {1'b0, opt[`CCS_OPT_IO_LSB +: 2]};
   wire [2:0] opt_gsr = {1'b0, opt[`CCS_OPT_GSR_LSB +: 2]};
   wire [2:0] step_done = (opt_valid && opt_done != 3'h0) ? opt_done : `CCS_STEP_DONE_DEF;
   wire [2:0] step_io = (opt_valid && opt_io != 3'h0) ? opt_io : `CCS_STEP_IO_DEF;
   wire [2:0] step_gsr = (opt_valid && opt_gsr != 3'h0) ? opt_gsr : `CCS_STEP_GSR_DEF;

   wire len_match = (state == ccs_pkg::CCS_ST_LOAD) && tick && (clk_count + 24'h000001 == len_count);
   wire starting = (state == ccs_pkg::CCS_ST_START);

   always_comb
   begin
      next_state = state;
      unique case (state)
         ccs_pkg::CCS_ST_IDLE:
            if (wr_start)
               next_state = ccs_pkg::CCS_ST_LOAD;
         ccs_pkg::CCS_ST_LOAD:
            if (wr_abort)
               next_state = ccs_pkg::CCS_ST_IDLE;
            else if (len_match)
               next_state = ccs_pkg::CCS_ST_START;
         ccs_pkg::CCS_ST_START:
            if (wr_abort)
               next_state = ccs_pkg::CCS_ST_IDLE;
            else if (tick && step_cnt + 3'h1 == `CCS_STEP_FINISH)
               next_state = ccs_pkg::CCS_ST_FINISHED;
         ccs_pkg::CCS_ST_FINISHED:
            if (wr_abort)
               next_state = ccs_pkg::CCS_ST_IDLE;
      endcase
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
      begin
         state <= ccs_pkg::CCS_ST_IDLE;
         mode <= ccs_pkg::CCS_MODE_SLAVE_SERIAL;
      end
      else
      begin
         state <= next_state;
         if (idle && wr_start)
            mode <= next_mode;
      end
   end

   // Config clocks after memory init, then start-up steps
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n || idle)
      begin
         clk_count <= 24'h000000;
         step_cnt <= 3'h0;
      end
      else if (tick && state == ccs_pkg::CCS_ST_LOAD)
         clk_count <= clk_count + 24'h000001;
      else if (tick && starting)
         step_cnt <= step_cnt + 3'h1;
   end

   // Events placed independently on steps 1..3 of the config clock
   ccs_event u_evt_done
   (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n),
      .i_clear(idle),
      .i_active(starting || state == ccs_pkg::CCS_ST_FINISHED),
      .i_step_cnt(step_cnt),
      .i_step(step_done),
      .o_fired(done_fired)
   );

   ccs_event u_evt_io
   (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n),
      .i_clear(idle),
      .i_active(starting || state == ccs_pkg::CCS_ST_FINISHED),
      .i_step_cnt(step_cnt),
      .i_step(step_io),
      .o_fired(io_fired)
   );

   ccs_event u_evt_gsr
   (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n),
      .i_clear(idle),
      .i_active(starting || state == ccs_pkg::CCS_ST_FINISHED),
      .i_step_cnt(step_cnt),
      .i_step(step_gsr),
      .o_fired(gsr_fired)
   );

   // Config status pins drop their drive first; user outputs follow one cycle later
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
      begin
         cfg_drive <= 1'b1;
         o_user_io_en <= 1'b0;
      end
      else
      begin
         cfg_drive <= !io_fired;
         o_user_io_en <= io_fired && !cfg_drive && !i_wakeup_gts;
      end
   end

   assign o_high_during_load_pin = 1'b1;
   assign o_high_during_load_pin_oe_n = !cfg_drive;
   assign o_low_during_load_pin_n = 1'b0;
   assign o_low_during_load_pin_oe_n = !cfg_drive;

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
      begin
         o_done <= 1'b0;
         o_gsr <= 1'b1;
         o_clk_sel_user <= 1'b0;
      end
      else
      begin
         o_done <= done_fired;
         o_gsr <= !gsr_fired || i_wakeup_gsr;
         o_clk_sel_user <= !idle && (starting || state == ccs_pkg::CCS_ST_FINISHED);
      end
   end

   assign o_wakeup_primitive = '{done: o_done, gsr: o_gsr, io_en: o_user_io_en,
                                 finished: state == ccs_pkg::CCS_ST_FINISHED};

   // Registers; options apply whatever the mode
   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
      begin
         len_count <= `CCS_LEN_RESET;
         opt <= `CCS_OPT_RESET;
      end
      else if (apb_wr && idle)
      begin
         if (hit_len)
            len_count <= i_pwdata[23:0];
         if (hit_opt)
            opt <= i_pwdata;
      end
   end

   wire [31:0] stat_word = {18'h00000, 2'(state), 3'(mode), mode_pins, 1'b0, o_clk_sel_user,
                            o_wakeup_primitive.finished, o_user_io_en, o_gsr, o_done};
   wire [31:0] rd_mux = hit_len ? {8'h00, len_count} :
                        hit_opt ? {23'h000000, opt[8:0]} :
                        hit_stat ? stat_word :
                        hit_count ? {8'h00, clk_count} : 32'h00000000;

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_rst_n)
         o_prdata <= 32'h00000000;
      else if (apb_setup && !i_pwrite)
         o_prdata <= rd_mux;
   end

   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rst_n);

   a_pre_match_quiet: assert property ((state == ccs_pkg::CCS_ST_LOAD) |-> (!o_done && o_gsr && !o_user_io_en))
      else $error("Start-up outputs active before length count match");
   a_match_enters_start: assert property (len_match && !wr_abort |=> state == ccs_pkg::CCS_ST_START)
      else $error("Length count match did not start the sequence");
   a_io_after_cfg: assert property ($rose(o_user_io_en) |-> !cfg_drive && !$past(cfg_drive))
      else $error("User outputs enabled while config pins driven");
   a_io_off_loading: assert property ((state != ccs_pkg::CCS_ST_START && state != ccs_pkg::CCS_ST_FINISHED)
                                      |-> ##2 !o_user_io_en)
      else $error("User I/O active outside start-up");
   a_gsr_held: assert property ((starting && step_cnt < step_gsr && !gsr_fired) |=> o_gsr)
      else $error("Set/reset released before its step");
   a_done_step: assert property ((starting && step_cnt >= step_done && !wr_abort) |-> ##2 o_done)
      else $error("Completion flag late for its step");
   a_default_io: assert property ((!opt_valid && starting && step_cnt == 3'h2 && !i_wakeup_gts && !wr_abort)
                                  |-> ##3 o_user_io_en)
      else $error("Default I/O enable not two clocks after match");
   a_finish_step: assert property ($rose(state == ccs_pkg::CCS_ST_FINISHED) |-> $past(step_cnt) == 3'h3)
      else $error("Finished reached at wrong step");
   a_clk_handover: assert property ((starting && !wr_abort) |=> o_clk_sel_user)
      else $error("Clock not handed to user source");
   a_mode_decode: assert property ((idle && wr_start && mode_pins == 3'h0)
                                   |=> mode == ccs_pkg::CCS_MODE_MASTER_SERIAL)
      else $error("Mode pins decoded wrongly");
endmodule

// *** ccs_cfg_src.sv ***
// Config data source model: makes the config clock for slave modes.
// Assumes the bench enables it while a frame is being loaded and through the start-up steps after it.
`timescale 1ns/1ps
module ccs_cfg_src
#(
   parameter int HALF = 6
)
(
   input wire logic i_clk_sys,
   input wire logic i_go,
   output logic o_config_clock
);
   int cnt = 0;
   initial o_config_clock = 1'b0;
   // Clock stands low between frames, runs on past the length count
   always @(posedge i_clk_sys)
   begin
      if (!i_go)
      begin
         cnt <= 0;
         o_config_clock <= 1'b0;
      end
      else if (cnt == HALF - 1)
      begin
         cnt <= 0;
         o_config_clock <= !o_config_clock;
      end
      else
         cnt <= cnt + 1;
   end
endmodule

// *** tb_top.sv ***
// Testbench of the start-up sequencer: APB master, mode pins, slave clock source.
// Assumes the design answers APB in fewer than 50 clocks of the access phase.
`timescale 1ns/1ps
`include "ccs_params.svh"
module tb_top;
   localparam logic [2:0] CD [8] = '{3'h7, 3'h0, 3'h3, 3'h5, 3'h6, 3'h4, 3'h1, 3'h2};
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [2:0] pins = 3'h7;
   logic ugsr = 1'b0;
   logic ugts = 1'b0;
   logic go = 1'b0;
   logic src_clk;
   logic dev_clk;
   logic dev_oe_n;
   logic hd;
   logic hd_oe_n;
   logic ld_n;
   logic ld_oe_n;
   logic done;
   logic gsr;
   logic ioen;
   logic csel;
   logic pcfg = 1'b0;
   ccs_pkg::ccs_wakeup_t wk;
   int err_total = 0;
   int check_count = 0;
   logic [31:0] q;
   logic e;
   wire cfg = !dev_oe_n ? dev_clk : src_clk;
   // Master drive watched directly: the pin mux hides the last pulse when drive is released
   wire tclk = src_clk | dev_clk;
   wire [11:0] vec = {done, gsr, ioen, csel, hd_oe_n, ld_oe_n, hd, ld_n, wk};

   always #5 clk = ~clk;
   always @(posedge clk) pcfg <= tclk;

   ccs_top #(.CONFIG_CLOCK_DIV(16)) uut
   (
      .i_clk_sys(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
      .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_config_clock(cfg), .o_config_clock(dev_clk),
      .o_config_clock_oe_n(dev_oe_n), .i_mode_select_bit2(pins[2]),
      .i_mode_select_bit1(pins[1]), .i_mode_select_bit0(pins[0]),
      .o_high_during_load_pin(hd), .o_high_during_load_pin_oe_n(hd_oe_n),
      .o_low_during_load_pin_n(ld_n), .o_low_during_load_pin_oe_n(ld_oe_n),
      .o_done(done), .o_gsr(gsr), .o_user_io_en(ioen), .o_clk_sel_user(csel),
      .o_wakeup_primitive(wk), .i_wakeup_gsr(ugsr), .i_wakeup_gts(ugts)
   );

   ccs_cfg_src #(.HALF(6)) src
   (
      .i_clk_sys(clk), .i_go(go), .o_config_clock(src_clk)
   );

   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      check_count++;
      if (got !== ex)
      begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, ex, got);
      end
   endtask

   task automatic stop_test();
      $display("Mismatches %0d, comparisons %0d", err_total, check_count);
      if (err_total == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (n >= 50)
      begin
         err_total++;
         stop_test();
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask

   // Waits for a rising edge on the OR of source and device config clocks
   task automatic tick();
      int n;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (!(tclk === 1'b1 && pcfg === 1'b0) && n < 100);
      if (n >= 100)
      begin
         err_total++;
         stop_test();
      end
   endtask

   function automatic int stp(input logic [8:0] o, input int lsb, input int dv);
      return (o[8] && o[lsb+:2] != 2'h0) ? int'(o[lsb+:2]) : dv;
   endfunction

   // Expected pins k config ticks after the length-count match
   function automatic logic [31:0] expv(input logic [8:0] o, input int k);
      logic d;
      logic g;
      logic u;
      d = k >= stp(o, 0, 1);
      g = !(k >= stp(o, 4, 3));
      u = k >= stp(o, 2, 2);
      return {20'h0, d, g, u, k >= 0, u, u, 1'b1, 1'b0, d, g, u, k >= 4};
   endfunction

   initial
   begin
      logic [8:0] opt;
      int n;
      q = $urandom(94);
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk("reset pins", expv(9'h0, -1), 32'(vec));
      apb(0, `CCS_ADDR_LEN, 0);
      chk("len reset", 32'h00ffffff, q);
      apb(0, `CCS_ADDR_OPT, 0);
      chk("opt reset", 32'h00000000, q);
      apb(0, 12'h014, 0);
      chk("unmapped", 32'h00000001, {q[30:0], e});
      for (int m = 0; m < 8; m++)
      begin
         pins <= CD[m];
         repeat (4) @(posedge clk);
         apb(1, `CCS_ADDR_CTRL, 1);
         apb(0, `CCS_ADDR_STAT, 0);
         chk("mode", 32'({2'h1, 3'(m < 6 ? m : 6), CD[m]}), 32'(q[13:6]));
         apb(1, `CCS_ADDR_CTRL, 2);
      end
      for (int i = 0; i < 6; i++)
      begin
         n = 2 + $urandom % 5;
         opt = {1'b1, 2'h0, 6'($urandom)};
         if (i == 0) opt = 9'h000;
         if (i == 1) opt = 9'h100;
         if (i == 2) opt = 9'h115;
         if (i == 3) opt = 9'h13f;
         pins <= (i % 2) ? 3'h0 : 3'h7;
         apb(1, `CCS_ADDR_LEN, 32'(n));
         apb(1, `CCS_ADDR_OPT, 32'(opt));
         apb(0, `CCS_ADDR_OPT, 0);
         chk("opt", 32'(opt), q);
         apb(1, `CCS_ADDR_CTRL, 1);
         go <= !(i % 2);
         for (int t = 1; t <= n + 4; t++)
         begin
            tick();
            repeat (7) @(posedge clk);
            chk("wake", expv(opt, t - n), 32'(vec));
            chk("wake", expv(opt, t - n), 32'(vec));
            chk("config_clock oe_n", 32'(!((i % 2) == 1 && t < n + 4)), 32'(dev_oe_n));
         end
         go <= 1'b0;
         apb(0, `CCS_ADDR_STAT, 0);
         chk("stat", 32'h7d, 32'({q[13:12], q[4:0]}));
         if (i == 0)
         begin
            apb(1, `CCS_ADDR_LEN, 1);
            apb(0, `CCS_ADDR_LEN, 0);
            chk("len locked", 32'(n), q);
         end
         ugts <= 1'b1;
         ugsr <= 1'b1;
         repeat (4) @(posedge clk);
         chk("user ctl", 32'h2, {30'h0, gsr, ioen});
         ugts <= 1'b0;
         ugsr <= 1'b0;
         apb(1, `CCS_ADDR_CTRL, 2);
         repeat (3) @(posedge clk);
         chk("abort", expv(9'h0, -1), 32'(vec));
      end
      stop_test();
   end
endmodule
